// [bench/rsaio_drive_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ****
// Drive seen from the sequencing block
// ****
module rsaio_drive_model
  import rsaio_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire rsaio_cmd_s drive_cmd,
  input wire logic [4:0] stim,
  input wire logic fault,
  output rsaio_drive_s drive_flags
);
  logic [15:0] health_q;
  logic ack_q;
  // Only a rising acknowledge clears a stored fault, never a held one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      health_q <= 16'h0000;
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= drive_cmd.alarm_ack;
      if (fault)
        health_q <= 16'h0001;
      else if (drive_cmd.alarm_ack && !ack_q)
        health_q <= 16'h0000;
    end
  end
  assign drive_flags = '{coast_stop: stim[0], fast_stop: stim[1],
    running: stim[2] & drive_cmd.run, enabled: drive_cmd.enable, zero_speed: stim[3],
    healthy: (health_q == 16'h0000), ready: stim[4], health_store: health_q};
endmodule // rsaio_drive_model
`default_nettype wire

// [bench/rsaio_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checks
// ****
module rsaio_properties
  import rsaio_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic run_terminal,
  input wire logic second_digital_terminal,
  input wire logic third_digital_terminal,
  input wire logic alt_inch_source,
  input wire logic alt_enable_source,
  input wire rsaio_cmd_s drive_cmd,
  input wire logic signed [15:0] soft_analog_output_1,
  input wire logic signed [15:0] soft_analog_output_2,
  input wire logic remote_trip_active,
  input wire logic [1:0] remote_trip_status
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ZERO_WAIT: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  AST_RUN_GATED: assert property (clk_en && !run_terminal |=> !drive_cmd.run)
    else $error("run command without run terminal");
  AST_INCH_GATED: assert property (
    clk_en && !second_digital_terminal && !alt_inch_source |=> !drive_cmd.inch)
    else $error("inch command without inch source");
  AST_ENABLE_GATED: assert property (
    clk_en && !third_digital_terminal && !alt_enable_source |=> !drive_cmd.enable)
    else $error("enable command without enable source");
  AST_ANALOG_RANGE: assert property (
    soft_analog_output_1 <= RSAIO_ANALOG_MAX && soft_analog_output_1 >= RSAIO_ANALOG_MIN &&
    soft_analog_output_2 <= RSAIO_ANALOG_MAX && soft_analog_output_2 >= RSAIO_ANALOG_MIN)
    else $error("analog output out of range");
  AST_TRIP_LATCH: assert property (
    remote_trip_status == 2'd2 |-> ##[0:4] remote_trip_active)
    else $error("active trip not latched");
  AST_TRIP_NO_RUN: assert property (remote_trip_active [*2] |-> !drive_cmd.run)
    else $error("run while tripped");
  AST_TRIP_CODE: assert property (remote_trip_status != 2'd3)
    else $error("undefined trip status");
endmodule // rsaio_properties
bind rsaio_remote_seq rsaio_properties u_props (.hclk, .hresetn, .clk_en, .hreadyout, .hresp,
  .run_terminal, .second_digital_terminal, .third_digital_terminal, .alt_inch_source,
  .alt_enable_source, .drive_cmd, .soft_analog_output_1, .soft_analog_output_2,
  .remote_trip_active, .remote_trip_status);
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
// ****
// Testbench
// ****
module testbench
  import rsaio_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata, v, r, s = 32'h429c72c9, exp_q[$], msk_q[$];
  logic run_terminal = 1'b1, second_digital_terminal = 1'b1, third_digital_terminal = 1'b1;
  logic alt_inch_source = 1'b0, alt_enable_source = 1'b0, fault = 1'b0, er, ei, ee;
  logic clk_en = 1'b1;
  logic [4:0] stim = 5'h00;
  logic signed [15:0] analog_input_1 = 16'sh0000, soft_analog_output_1, soft_analog_output_2;
  logic soft_digital_output_1, soft_digital_output_2, soft_digital_output_3;
  logic remote_trip_active;
  logic [1:0] remote_trip_status;
  rsaio_drive_s drive_flags;
  rsaio_cmd_s drive_cmd;
  logic [15:0] cws [5] = '{16'h0201, 16'h0203, 16'h0205, 16'h020c, 16'h0300};
  int errors = 0, cmp_count = 0, n;
  event rd_ev;
  assign hready = hreadyout;
  always #20 hclk = ~hclk;
  rsaio_remote_seq DUT (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .run_terminal,
    .second_digital_terminal, .third_digital_terminal, .alt_inch_source, .alt_enable_source,
    .analog_input_1, .drive_flags, .drive_cmd, .soft_digital_output_1, .soft_digital_output_2,
    .soft_digital_output_3, .soft_analog_output_1, .soft_analog_output_2, .remote_trip_active,
    .remote_trip_status);
  rsaio_drive_model u_drive (.hclk, .hresetn, .drive_cmd, .stim, .fault, .drive_flags);
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  // Address phase, then data phase; both end on a sampled hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
    -> rd_ev;
  endtask
  always @(rd_ev) chk("hrdata", exp_q.pop_front(), r & msk_q.pop_front());
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #(40 * 90000);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    cyc(2);
    hresetn <= 1'b1;
    cyc(1);
    rd(RSAIO_ADDR_CTRL_WORD, {16'h0, RSAIO_CW_RESET}, 32'hffff);
    rd(RSAIO_ADDR_AUX_CMD, 32'h7, 32'hf);
    rd(RSAIO_ADDR_TRIP_CFG, {16'h0, RSAIO_TRIP_DELAY_RESET}, 32'h7ffff);
    rd(8'h1c, 32'h0, 32'hffffffff);
    bus(1'b1, RSAIO_ADDR_STATUS_WORD, 32'hffff);
    rd(RSAIO_ADDR_STATUS_WORD, 32'h0, 32'hffffe0a0);
    chk("trip_status", 2'd0, remote_trip_status);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, RSAIO_ADDR_AUX_CMD, i);
      v = xs();
      {run_terminal, second_digital_terminal, third_digital_terminal} <= v[2:0];
      {alt_inch_source, alt_enable_source} <= v[4:3];
      cyc(3);
      er = v[2] & i[0];
      ei = v[1] & i[1];
      ee = v[0] & i[2];
      chk("run", er, drive_cmd.run);
      chk("inch", ei, drive_cmd.inch);
      chk("enable", ee, drive_cmd.enable);
      chk("ack", 1'b1, drive_cmd.alarm_ack);
      rd(RSAIO_ADDR_STATUS_WORD, {ei, er, !ee, 2'b00}, 32'h1c);
    end
    bus(1'b1, RSAIO_ADDR_ROUTE, 32'h3);
    {second_digital_terminal, third_digital_terminal} <= 2'b00;
    {alt_inch_source, alt_enable_source} <= 2'b11;
    cyc(3);
    chk("alt_inch", 1'b1, drive_cmd.inch);
    chk("alt_enable", 1'b1, drive_cmd.enable);
    bus(1'b1, RSAIO_ADDR_ROUTE, 32'h0);
    $display("test terminal gating done");
    bus(1'b1, RSAIO_ADDR_AUX_CMD, 32'hf);
    {run_terminal, second_digital_terminal, third_digital_terminal} <= 3'b111;
    foreach (cws[k])
    begin
      bus(1'b1, RSAIO_ADDR_CTRL_WORD, cws[k]);
      cyc(3);
      chk("cmd", {cws[k][0], cws[k][1], cws[k][2], cws[k][3], cws[k][8]}, {drive_cmd.enable,
        drive_cmd.run, drive_cmd.inch, drive_cmd.jog_mode, drive_cmd.alarm_ack});
      rd(RSAIO_ADDR_CTRL_WORD, cws[k], 32'hffff);
    end
    $display("test control word done");
    bus(1'b1, RSAIO_ADDR_CTRL_WORD, 32'h0201);
    fault <= 1'b1;
    cyc(1);
    fault <= 1'b0;
    cyc(3);
    rd(RSAIO_ADDR_STATUS_WORD, 32'h0040, 32'h0840);
    bus(1'b1, RSAIO_ADDR_CTRL_WORD, 32'h0301);
    cyc(4);
    rd(RSAIO_ADDR_STATUS_WORD, 32'h0840, 32'h0840);
    bus(1'b1, RSAIO_ADDR_CTRL_WORD, 32'h0203);
    cyc(4);
    rd(RSAIO_ADDR_STATUS_WORD, 32'h0800, 32'h0840);
    repeat (4)
    begin
      v = xs();
      stim <= v[4:0];
      cyc(3);
      rd(RSAIO_ADDR_STATUS_WORD, {3'b0, drive_flags.ready, drive_flags.healthy,
        drive_flags.zero_speed, drive_flags.enabled, drive_flags.running, 6'b0,
        drive_flags.fast_stop, drive_flags.coast_stop}, 32'h1f03);
    end
    $display("test status done");
    v = xs();
    bus(1'b1, RSAIO_ADDR_SOFT_OUT, v);
    cyc(3);
    chk("dout", v[2:0], {soft_digital_output_3, soft_digital_output_2,
      soft_digital_output_1});
    clk_en <= 1'b0;
    bus(1'b1, RSAIO_ADDR_SOFT_OUT, ~v);
    clk_en <= 1'b1;
    cyc(3);
    chk("freeze", v[2:0], {soft_digital_output_3, soft_digital_output_2,
      soft_digital_output_1});
    bus(1'b1, RSAIO_ADDR_ANALOG, 32'h80007fff);
    cyc(3);
    chk("analog", 32'hd8f02710, {soft_analog_output_2, soft_analog_output_1});
    bus(1'b1, RSAIO_ADDR_ROUTE, 32'h4);
    analog_input_1 <= 16'h0 - {3'b0, v[12:0]};
    cyc(3);
    chk("relay", {16'h0, 16'(16'h0 - {3'b0, v[12:0]})}, {16'h0, soft_analog_output_1});
    bus(1'b1, RSAIO_ADDR_ROUTE, 32'h0);
    $display("test soft outputs done");
    bus(1'b1, RSAIO_ADDR_TRIP_CFG, 32'h1);
    bus(1'b1, RSAIO_ADDR_CTRL_WORD, 32'h0003);
    cyc(3);
    chk("warn", 2'd1, remote_trip_status);
    n = 0;
    while (remote_trip_status !== 2'd2 && n < 60000)
    begin
      cyc(1);
      n++;
    end
    chk("trip_time", 1'b1, n >= 24990 && n < 25100);
    cyc(1);
    chk("trip_cmd", 1'b1, drive_cmd.remote_trip);
    bus(1'b1, RSAIO_ADDR_CTRL_WORD, 32'h0203);
    cyc(4);
    chk("latched", 2'b10, {remote_trip_active, drive_cmd.run});
    bus(1'b1, RSAIO_ADDR_CTRL_WORD, 32'h0301);
    bus(1'b1, RSAIO_ADDR_CTRL_WORD, 32'h0203);
    cyc(4);
    chk("restart", 2'b01, {remote_trip_active, drive_cmd.run});
    bus(1'b1, RSAIO_ADDR_TRIP_CFG, 32'h10001);
    bus(1'b1, RSAIO_ADDR_CTRL_WORD, 32'h0003);
    cyc(26000);
    chk("inhibit", 1'b0, remote_trip_active);
    chk("inhibit_status", 2'd0, remote_trip_status);
    $display("test remote trip done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire

// [core/rsaio_pkg.sv]
package rsaio_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] RSAIO_ADDR_CTRL_WORD = 8'h00;
  localparam logic [7:0] RSAIO_ADDR_STATUS_WORD = 8'h04;
  localparam logic [7:0] RSAIO_ADDR_AUX_CMD = 8'h08;
  localparam logic [7:0] RSAIO_ADDR_SOFT_OUT = 8'h0c;
  localparam logic [7:0] RSAIO_ADDR_ANALOG = 8'h10;
  localparam logic [7:0] RSAIO_ADDR_TRIP_CFG = 8'h14;
  localparam logic [7:0] RSAIO_ADDR_ROUTE = 8'h18;

  // ****************************************
  // Control word fields
  // ****************************************
  localparam int RSAIO_CW_ENABLE = 0;
  localparam int RSAIO_CW_START = 1;
  localparam int RSAIO_CW_JOG = 2;
  localparam int RSAIO_CW_JOG_MODE = 3;
  localparam int RSAIO_CW_ALARM_ACK = 8;
  localparam int RSAIO_CW_TRIP_N = 9;
  localparam logic [15:0] RSAIO_CW_RESET = 16'h0000;

  // ****************************************
  // Status word fields
  // ****************************************
  localparam int RSAIO_SW_COAST = 0;
  localparam int RSAIO_SW_FAST_STOP = 1;
  localparam int RSAIO_SW_DISABLE = 2;
  localparam int RSAIO_SW_RUN = 3;
  localparam int RSAIO_SW_JOG = 4;
  localparam int RSAIO_SW_ALARM = 6;
  localparam int RSAIO_SW_RUNNING = 8;
  localparam int RSAIO_SW_ENABLED = 9;
  localparam int RSAIO_SW_ZERO_SPEED = 10;
  localparam int RSAIO_SW_HEALTHY = 11;
  localparam int RSAIO_SW_READY = 12;

  // ****************************************
  // Aux command / trip config / route fields
  // ****************************************
  localparam int RSAIO_AUX_START = 0;
  localparam int RSAIO_AUX_JOG = 1;
  localparam int RSAIO_AUX_ENABLE = 2;
  localparam int RSAIO_AUX_GATE = 3;
  localparam logic [3:0] RSAIO_AUX_RESET = 4'h7;
  localparam int RSAIO_TRIP_DISABLE_BIT = 16;
  localparam int RSAIO_ROUTE_JOG_SEL = 0;
  localparam int RSAIO_ROUTE_EN_SEL = 1;
  localparam int RSAIO_ROUTE_AN1_SEL = 2;

  // Analog values: signed hundredths of a percent
  localparam logic signed [15:0] RSAIO_ANALOG_MAX = 16'sd10000;
  localparam logic signed [15:0] RSAIO_ANALOG_MIN = -16'sd10000;

  // ****************************************
  // Timing: link loss trip delay in milliseconds
  // ****************************************
  localparam int RSAIO_CLK_HZ = 25000000;
  localparam int RSAIO_TICK_US = 1000;
  localparam int RSAIO_TICK_CYCLES = RSAIO_CLK_HZ / 1000000 * RSAIO_TICK_US;
  localparam logic [15:0] RSAIO_TRIP_DELAY_RESET = 16'h0064;

  typedef enum logic [1:0] {RSAIO_TRIP_OK, RSAIO_TRIP_WARN, RSAIO_TRIP_ACTIVE} rsaio_trip_e;

  typedef struct packed {
    logic start;
    logic jog;
    logic enable;
  } rsaio_term_s;

  typedef struct packed {
    logic coast_stop;
    logic fast_stop;
    logic running;
    logic enabled;
    logic zero_speed;
    logic healthy;
    logic ready;
    logic [15:0] health_store;
  } rsaio_drive_s;

  typedef struct packed {
    logic run;
    logic inch;
    logic enable;
    logic jog_mode;
    logic alarm_ack;
    logic remote_trip;
  } rsaio_cmd_s;

endpackage

// [core/rsaio_remote_seq.sv]
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Effective run, inch, enable = terminal input AND software aux command bit.
// - Start, jog, enable terminals pass through this block to drive logic.
// - Three soft digital and two soft analog outputs drive output terminals.
// - Soft analog values clamp to -100.00..100.00 percent; may relay an input.
// - Control word acts only while the remote sequencing gate is set.
// - Control word is 16 bits, reset to zero.
// - Control bit 9 low requests a remote trip; high means normal.
// - Status word is read-only, 16 bits, reserved bits read zero.
// - Status bits 0..4: coast, fast stop, disable, start, jog demands.
// - Status bit 6 sets when stored health word is non-zero; holds until run while healthy.
// - Status bit 8 contactor in and ready; bit 9 drive enabled.
// - Status bit 10 mirrors zero speed.
// - Status bit 11 mirrors healthy.
// - Status bit 12 mirrors ready.
// - After trip acknowledge, healthy returns, alarm stays until restart.
// - Inching input defaults to the second digital terminal.
// - Current control enable defaults to the third digital terminal.
// - Alarm acknowledge is forced true when remote sequencing is off.
// - Trip after programmable delay unless disabled; restart needs ack and start edges.
module rsaio_remote_seq
  import rsaio_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic run_terminal,
  input wire logic second_digital_terminal,
  input wire logic third_digital_terminal,
  input wire logic alt_inch_source,
  input wire logic alt_enable_source,
  input wire logic signed [15:0] analog_input_1,
  input wire rsaio_drive_s drive_flags,
  output rsaio_cmd_s drive_cmd,
  output logic soft_digital_output_1,
  output logic soft_digital_output_2,
  output logic soft_digital_output_3,
  output logic signed [15:0] soft_analog_output_1,
  output logic signed [15:0] soft_analog_output_2,
  output logic remote_trip_active,
  output logic [1:0] remote_trip_status
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [15:0] ctrl_q;
  logic [3:0] aux_q;
  logic [2:0] dout_q;
  logic signed [15:0] an1_q;
  logic signed [15:0] an2_q;
  logic [15:0] trip_delay_q;
  logic trip_disable_q;
  logic [2:0] route_q;
  logic [31:0] hrdata_q;
  logic [15:0] status_w;
  logic alarm_q;
  logic tripped_q;
  logic ack_prev_q;
  logic start_prev_q;
  logic ack_seen_q;
  logic [15:0] ms_cnt_q;
  logic [$clog2(RSAIO_TICK_CYCLES)-1:0] tick_cnt_q;
  rsaio_trip_e trip_q;
  rsaio_term_s term_w;
  logic gate_w;
  logic ack_w;
  logic start_w;
  logic addr_ph;

  assign addr_ph = hsel && hready && htrans[1] && clk_en;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  function automatic logic signed [15:0] clamp_pct(input logic [15:0] v);
    logic signed [15:0] s;
    s = $signed(v);
    if (s > RSAIO_ANALOG_MAX)
      return RSAIO_ANALOG_MAX;
    else if (s < RSAIO_ANALOG_MIN)
      return RSAIO_ANALOG_MIN;
    return s;
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (clk_en)
    begin
      wr_pend_q <= addr_ph && hwrite;
      addr_q <= haddr;
    end
  end

  // Writes complete in the data phase; zero wait states
  // Back-to-back read of a just-written register would see the old value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= RSAIO_CW_RESET;
      aux_q <= RSAIO_AUX_RESET;
      dout_q <= 3'h0;
      an1_q <= 16'sh0000;
      an2_q <= 16'sh0000;
      trip_delay_q <= RSAIO_TRIP_DELAY_RESET;
      trip_disable_q <= 1'b0;
      route_q <= 3'h0;
    end
    else if (clk_en && wr_pend_q)
    begin
      case (addr_q)
        RSAIO_ADDR_CTRL_WORD: ctrl_q <= hwdata[15:0];
        RSAIO_ADDR_AUX_CMD: aux_q <= hwdata[3:0];
        RSAIO_ADDR_SOFT_OUT: dout_q <= hwdata[2:0];
        RSAIO_ADDR_ANALOG:
        begin
          an1_q <= clamp_pct(hwdata[15:0]);
          an2_q <= clamp_pct(hwdata[31:16]);
        end
        RSAIO_ADDR_TRIP_CFG:
        begin
          trip_delay_q <= hwdata[15:0];
          trip_disable_q <= hwdata[RSAIO_TRIP_DISABLE_BIT];
        end
        RSAIO_ADDR_ROUTE: route_q <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data sampled at the address phase so it stands in the data phase
  // Reserved and unmapped bits read zero; software must not rely on them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h0000_0000;
    else if (addr_ph && !hwrite)
    begin
      case (haddr)
        RSAIO_ADDR_CTRL_WORD: hrdata_q <= {16'h0000, ctrl_q};
        RSAIO_ADDR_STATUS_WORD: hrdata_q <= {16'h0000, status_w};
        RSAIO_ADDR_AUX_CMD: hrdata_q <= {28'h0, aux_q};
        RSAIO_ADDR_SOFT_OUT: hrdata_q <= {29'h0, dout_q};
        RSAIO_ADDR_ANALOG: hrdata_q <= {an2_q, an1_q};
        RSAIO_ADDR_TRIP_CFG:
          hrdata_q <= {13'h0, trip_q, trip_disable_q, trip_delay_q};
        RSAIO_ADDR_ROUTE: hrdata_q <= {29'h0, route_q};
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Sequencing gate and command merge
  // ****************************************
  assign gate_w = aux_q[RSAIO_AUX_GATE];
  // Terminal sources; alternate routing is a config choice, default is the terminal
  assign term_w.start = run_terminal;
  assign term_w.jog = route_q[RSAIO_ROUTE_JOG_SEL] ? alt_inch_source
                                                   : second_digital_terminal;
  assign term_w.enable = route_q[RSAIO_ROUTE_EN_SEL] ? alt_enable_source
                                                     : third_digital_terminal;
  assign ack_w = gate_w ? ctrl_q[RSAIO_CW_ALARM_ACK] : 1'b1;
  assign start_w = term_w.start && aux_q[RSAIO_AUX_START]
                   && (!gate_w || ctrl_q[RSAIO_CW_START]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      drive_cmd <= '0;
    else if (clk_en)
    begin
      drive_cmd.run <= start_w && !tripped_q;
      drive_cmd.inch <= term_w.jog && aux_q[RSAIO_AUX_JOG]
                        && (!gate_w || ctrl_q[RSAIO_CW_JOG]);
      drive_cmd.enable <= term_w.enable && aux_q[RSAIO_AUX_ENABLE]
                          && (!gate_w || ctrl_q[RSAIO_CW_ENABLE]);
      drive_cmd.jog_mode <= gate_w && ctrl_q[RSAIO_CW_JOG_MODE];
      drive_cmd.alarm_ack <= ack_w;
      drive_cmd.remote_trip <= trip_q == RSAIO_TRIP_ACTIVE;
    end
  end

  // ****************************************
  // Soft outputs
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      soft_digital_output_1 <= 1'b0;
      soft_digital_output_2 <= 1'b0;
      soft_digital_output_3 <= 1'b0;
      soft_analog_output_1 <= 16'sh0000;
      soft_analog_output_2 <= 16'sh0000;
    end
    else if (clk_en)
    begin
      {soft_digital_output_3, soft_digital_output_2, soft_digital_output_1} <= dout_q;
      // Staging post: output 1 can relay an analog input, clamped to range
      soft_analog_output_1 <= route_q[RSAIO_ROUTE_AN1_SEL] ? clamp_pct(analog_input_1)
                                                           : an1_q;
      soft_analog_output_2 <= an2_q;
    end
  end

  // ****************************************
  // Link loss trip timer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trip_q <= RSAIO_TRIP_OK;
      tick_cnt_q <= '0;
      ms_cnt_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      case (trip_q)
        RSAIO_TRIP_OK:
        begin
          tick_cnt_q <= '0;
          ms_cnt_q <= 16'h0000;
          if (gate_w && !ctrl_q[RSAIO_CW_TRIP_N] && !trip_disable_q)
            trip_q <= RSAIO_TRIP_WARN;
        end
        // Bit 9 returning high or the gate clearing before expiry restarts the count
        RSAIO_TRIP_WARN:
        begin
          if (!gate_w || ctrl_q[RSAIO_CW_TRIP_N] || trip_disable_q)
            trip_q <= RSAIO_TRIP_OK;
          else if (ms_cnt_q >= trip_delay_q)
            trip_q <= RSAIO_TRIP_ACTIVE;
          else if (tick_cnt_q == ($clog2(RSAIO_TICK_CYCLES))'(RSAIO_TICK_CYCLES - 1))
          begin
            tick_cnt_q <= '0;
            ms_cnt_q <= ms_cnt_q + 16'h0001;
          end
          else
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
        RSAIO_TRIP_ACTIVE:
          if (ctrl_q[RSAIO_CW_TRIP_N] || !gate_w)
            trip_q <= RSAIO_TRIP_OK;
        default: trip_q <= RSAIO_TRIP_OK;
      endcase
    end
  end

  // Latched trip clears only after an ack rising edge then a start rising edge
  // A start edge without an earlier ack edge leaves the drive locked out
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tripped_q <= 1'b0;
      ack_seen_q <= 1'b0;
      // High so the forced ack after reset does not look like an edge
      ack_prev_q <= 1'b1;
      start_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ack_prev_q <= ack_w;
      start_prev_q <= start_w;
      if (trip_q == RSAIO_TRIP_ACTIVE)
      begin
        tripped_q <= 1'b1;
        ack_seen_q <= 1'b0;
      end
      else if (tripped_q)
      begin
        if (ack_w && !ack_prev_q)
          ack_seen_q <= 1'b1;
        if (ack_seen_q && start_w && !start_prev_q)
          tripped_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  // Alarm holds after health clears until the drive is started again
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alarm_q <= 1'b0;
    else if (clk_en)
    begin
      if (drive_flags.health_store != 16'h0000)
        alarm_q <= 1'b1;
      else if (drive_cmd.run && drive_flags.healthy)
        alarm_q <= 1'b0;
    end
  end

  assign remote_trip_active = tripped_q;
  assign remote_trip_status = trip_q;

  always_comb
  begin
    status_w = 16'h0000;
    status_w[RSAIO_SW_COAST] = drive_flags.coast_stop;
    status_w[RSAIO_SW_FAST_STOP] = drive_flags.fast_stop;
    status_w[RSAIO_SW_DISABLE] = !drive_cmd.enable;
    status_w[RSAIO_SW_RUN] = drive_cmd.run;
    status_w[RSAIO_SW_JOG] = drive_cmd.inch;
    status_w[RSAIO_SW_ALARM] = alarm_q;
    status_w[RSAIO_SW_RUNNING] = drive_flags.running;
    status_w[RSAIO_SW_ENABLED] = drive_flags.enabled;
    status_w[RSAIO_SW_ZERO_SPEED] = drive_flags.zero_speed;
    status_w[RSAIO_SW_HEALTHY] = drive_flags.healthy;
    status_w[RSAIO_SW_READY] = drive_flags.ready;
  end

endmodule // rsaio_remote_seq
`default_nettype wire
